// file: src/audio_embed_ctrl.sv
// Control, mixing, metering and embedding logic of the four-channel audio embedder.
// Notes on behaviour
// - Report input: none, 525 lock, 625 lock.
// - Mux mode is overwrite or append.
// - Overwrite drops incoming embedded audio.
// - Append keeps incoming embedded audio.
// - Report selected group and its audio presence.
// - Select group one to four; mark insertions.
// - Reference level is -20 or -18 dBFS.
// - Reference level sets the zero-VU point.
// - Peak threshold: clipping or 2-10 dB.
// - Strip removes audio and EDH packets.
// - Flag peaks above the headroom threshold.
// - Three level bands per output.
// - Gain per input from -70 to +12 dB.
// - Route each input to any outputs.
// - Tied pairs share every gain change.
// - Default command sets gain to 0 dB.
// - Per-channel polarity inversion.
// - Inputs carry 20 or 24 bit samples.
// - Hold samples, mix at 48 kHz.
`timescale 1ns/1ps
module audio_embed_ctrl #(
	parameter int unsigned TICK       = embed_ctrl_pkg::TICK_CYCLES,
	parameter int unsigned GROUP_HOLD = embed_ctrl_pkg::GROUP_HOLD_CYCLES
) (
	// Clock and reset.
	input  wire logic                    hclk,
	input  wire logic                    hresetn,
	// AHB-Lite slave.
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic                         hreadyout,
	output logic                         hresp,
	output logic [31:0]                  hrdata,
	// Receiver status pins.
	input  wire logic                    vid_lock_pin,
	input  wire logic                    vid_625_pin,
	// Video stream.
	input  wire embed_ctrl_pkg::vid_word_t vid_in,
	output embed_ctrl_pkg::vid_word_t      vid_out,
	// Rate-converted stereo inputs.
	input  wire embed_ctrl_pkg::aes_pair_t aes_a,
	input  wire embed_ctrl_pkg::aes_pair_t aes_b
);
	import embed_ctrl_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.

	logic               wr_pend_q;     // Write data phase under way.
	logic               rd_wait_q;     // Read data phase, first cycle.
	logic [7:0]         addr_q;        // Captured byte address.
	logic [31:0]        rd_val;        // Read mux result.
	logic [31:0]        hrdata_q;
	logic               accept;        // Address phase taken.
	logic               lock_s1_q, lock_s2_q, std_s1_q, std_s2_q;
	mux_mode_t          mode_q;
	logic [1:0]         grp_sel_q;
	logic               ref18_q;       // Reference level is -18 dBFS when set.
	logic [2:0]         peak_sel_q;
	logic               strip_q;
	logic [1:0]         w20_q;         // 20-bit input per stereo pair.
	logic [1:0]         tie_q;         // Gain tie per pair.
	logic [3:0]         inv_q;
	logic [15:0]        route_q;       // Nibble i lists outputs fed by input i.
	logic signed [7:0]  gain_q [4];
	logic [23:0]        smp_q [4];     // Held input samples.
	logic signed [26:0] scaled [4];
	logic [23:0]        mix_q [4];
	logic [12:0]        tick_cnt_q;
	logic               tick;
	logic [3:0]         peak_q;
	logic [7:0]         band_q;
	logic [23:0]        hold_cnt_q;
	logic [1:0]         ins_ch_q, ins_byte_q;
	vid_word_t          vid_q;
	pres_t              pres;

	// Clamp of a written gain into the legal range.
	function automatic logic signed [7:0] clamp_gain(input logic signed [7:0] g);
		if (g < GAIN_MIN) begin
			return GAIN_MIN;
		end else if (g > GAIN_MAX) begin
			return GAIN_MAX;
		end
		return g;
	endfunction

	// Magnitude of a sample; the most negative code maps to full scale plus one.
	function automatic logic [23:0] mag(input logic [23:0] s);
		return s[23] ? 24'(-s) : s;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave. Writes take no wait state; reads take one so that a read after a
	// write always returns the new value.

	assign accept    = hsel && htrans[1] && hready;
	assign hreadyout = !rd_wait_q;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;

	// Address phase capture.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_wait_q <= 1'b0;
			addr_q    <= 8'h00;
		end else begin
			wr_pend_q <= accept && hwrite;
			rd_wait_q <= accept && !hwrite;
			if (accept) begin
				addr_q <= haddr[7:0];
			end
		end
	end

	// Read mux; unmapped offsets read as zero.
	always_comb begin
		rd_val = 32'h0;
		unique case (addr_q)
			REG_CTRL: begin
				rd_val[CTRL_MODE_BIT]                = mode_q;
				rd_val[CTRL_GRP_LSB +: 2]            = grp_sel_q;
				rd_val[CTRL_REF_BIT]                 = ref18_q;
				rd_val[CTRL_PEAK_LSB +: 3]           = peak_sel_q;
				rd_val[CTRL_STRIP_BIT]               = strip_q;
				rd_val[CTRL_W20_LSB +: 2]            = w20_q;
			end
			REG_STATUS: begin
				rd_val[1:0]                          = pres;
				rd_val[STAT_GRP_LSB +: 2]            = grp_sel_q;
				rd_val[STAT_GVAL_BIT]                = hold_cnt_q != 24'h0;
			end
			REG_CHAN: begin
				rd_val[CHAN_TIE_LSB +: 2]            = tie_q;
				rd_val[CHAN_INV_LSB +: 4]            = inv_q;
			end
			REG_ROUTE: rd_val[15:0]                 = route_q;
			REG_GAIN0: rd_val                       = 32'(gain_q[0]);
			REG_GAIN0 + REG_STEP: rd_val            = 32'(gain_q[1]);
			REG_GAIN0 + 2 * REG_STEP: rd_val        = 32'(gain_q[2]);
			REG_GAIN0 + 3 * REG_STEP: rd_val        = 32'(gain_q[3]);
			REG_METER: rd_val[11:0]                 = {band_q, peak_q};
			default: rd_val = 32'h0;
		endcase
	end

	// Read data register, loaded during the wait cycle.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0;
		end else if (rd_wait_q) begin
			hrdata_q <= rd_val;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control registers.

	// Control word and channel options.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q     <= MODE_OVERWRITE;
			grp_sel_q  <= 2'h0;
			ref18_q    <= 1'b0;
			peak_sel_q <= 3'h0;
			strip_q    <= 1'b0;
			w20_q      <= 2'h0;
			tie_q      <= 2'h0;
			inv_q      <= 4'h0;
			route_q    <= 16'h8421; // Each input starts on its own output.
		end else if (wr_pend_q) begin
			if (addr_q == REG_CTRL) begin
				mode_q     <= mux_mode_t'(hwdata[CTRL_MODE_BIT]);
				grp_sel_q  <= hwdata[CTRL_GRP_LSB +: 2];
				ref18_q    <= hwdata[CTRL_REF_BIT];
				// Codes above five are kept but act as the 10 dB setting.
				peak_sel_q <= hwdata[CTRL_PEAK_LSB +: 3];
				strip_q    <= hwdata[CTRL_STRIP_BIT];
				w20_q      <= hwdata[CTRL_W20_LSB +: 2];
			end
			if (addr_q == REG_CHAN) begin
				tie_q <= hwdata[CHAN_TIE_LSB +: 2];
				inv_q <= hwdata[CHAN_INV_LSB +: 4];
			end
			if (addr_q == REG_ROUTE) begin
				route_q <= hwdata[15:0];
			end
		end
	end

	// Gains. A write or a default command on a tied channel moves its partner too.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 4; i++) begin
				gain_q[i] <= GAIN_UNITY;
			end
		end else if (wr_pend_q) begin
			for (int i = 0; i < 4; i++) begin
				for (int j = 0; j < 4; j++) begin
					if (j == i || (tie_q[i / 2] && j == (i ^ 1))) begin
						if (addr_q == REG_GAIN0 + 8'(j) * REG_STEP) begin
							gain_q[i] <= clamp_gain(hwdata[7:0]);
						end
						if (addr_q == REG_CHAN && hwdata[CHAN_DEF_LSB + j]) begin
							gain_q[i] <= GAIN_UNITY;
						end
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Input status. The pins are asynchronous and pass two flops first.

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_s1_q <= 1'b0;
			lock_s2_q <= 1'b0;
			std_s1_q  <= 1'b0;
			std_s2_q  <= 1'b0;
		end else begin
			lock_s1_q <= vid_lock_pin;
			lock_s2_q <= lock_s1_q;
			std_s1_q  <= vid_625_pin;
			std_s2_q  <= std_s1_q;
		end
	end

	assign pres = !lock_s2_q ? PRES_NONE : (std_s2_q ? PRES_625 : PRES_525);

	// Group presence: any packet of the selected group restarts a hold timer.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold_cnt_q <= 24'h0;
		end else if (vid_in.valid && vid_in.audio && vid_in.group == grp_sel_q) begin
			hold_cnt_q <= 24'(GROUP_HOLD);
		end else if (hold_cnt_q != 24'h0) begin
			hold_cnt_q <= hold_cnt_q - 24'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Audio path. Inputs are held and resampled on a 48 kHz tick; this is a
	// zero-order hold, which is adequate for control but aliases on wide-band input.
	// Compressed streams survive only when the sources are already video locked.

	// Latest sample of each input channel, with 20-bit words trimmed.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 4; i++) begin
				smp_q[i] <= 24'h0;
			end
		end else begin
			if (aes_a.valid) begin
				smp_q[0] <= aes_a.left & (w20_q[0] ? W20_MASK : FULL_SCALE | 24'h800000);
				smp_q[1] <= aes_a.right & (w20_q[0] ? W20_MASK : FULL_SCALE | 24'h800000);
			end
			if (aes_b.valid) begin
				smp_q[2] <= aes_b.left & (w20_q[1] ? W20_MASK : FULL_SCALE | 24'h800000);
				smp_q[3] <= aes_b.right & (w20_q[1] ? W20_MASK : FULL_SCALE | 24'h800000);
			end
		end
	end

	// Output-rate tick.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_cnt_q <= 13'h0;
		end else if (tick) begin
			tick_cnt_q <= 13'h0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 13'h1;
		end
	end

	assign tick = tick_cnt_q == 13'(TICK - 1);

	// Gain and inversion stages.
	for (genvar g = 0; g < 4; g++) begin : g_gain
		chan_gain u_gain (
			.sample  (smp_q[g]),
			.gain_db (gain_q[g]),
			.invert  (inv_q[g]),
			.scaled  (scaled[g])
		);
	end

	// Mixer: each output sums the inputs routed to it and saturates.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int o = 0; o < 4; o++) begin
				mix_q[o] <= 24'h0;
			end
		end else if (tick) begin
			for (int o = 0; o < 4; o++) begin
				automatic logic signed [28:0] acc = '0;
				for (int i = 0; i < 4; i++) begin
					if (route_q[4 * i + o]) begin
						acc = acc + 29'(scaled[i]);
					end
				end
				if (acc > $signed({5'd0, FULL_SCALE})) begin
					mix_q[o] <= FULL_SCALE;
				end else if (acc < -$signed({5'd0, FULL_SCALE}) - 29'sd1) begin
					mix_q[o] <= ~FULL_SCALE;
				end else begin
					mix_q[o] <= acc[23:0];
				end
			end
		end
	end

	// Meters, refreshed one cycle after each mixed sample.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			peak_q <= 4'h0;
			band_q <= 8'h0;
		end else begin
			for (int o = 0; o < 4; o++) begin
				automatic logic [23:0] m   = mag(mix_q[o]);
				automatic logic [23:0] pk  = PEAK_10DB;
				automatic logic [23:0] vu0 = ref18_q ? VU0_REF18 : VU0_REF20;
				automatic logic [23:0] vu2 = ref18_q ? VU20_REF18 : VU20_REF20;
				unique case (peak_sel_q)
					3'd0: pk = PEAK_CLIP;
					3'd1: pk = PEAK_2DB;
					3'd2: pk = PEAK_4DB;
					3'd3: pk = PEAK_6DB;
					3'd4: pk = PEAK_8DB;
					default: pk = PEAK_10DB;
				endcase
				peak_q[o] <= m > pk;
				band_q[2 * o +: 2] <= m > vu0 ? BAND_HIGH : (m > vu2 ? BAND_MID : BAND_LOW);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Video path, one cycle of latency. Insertion slots carry the mixed outputs,
	// three bytes per channel, channels in turn.

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vid_q      <= '0;
			ins_ch_q   <= 2'h0;
			ins_byte_q <= 2'h0;
		end else begin
			vid_q <= vid_in;
			if (vid_in.valid && vid_in.slot) begin
				vid_q.data  <= {2'b00, mix_q[ins_ch_q][8 * ins_byte_q +: 8]};
				vid_q.audio <= 1'b1;
				vid_q.edh   <= 1'b0;
				vid_q.group <= grp_sel_q;
				ins_byte_q  <= ins_byte_q == LAST_BYTE ? 2'h0 : ins_byte_q + 2'h1;
				if (ins_byte_q == LAST_BYTE) begin
					ins_ch_q <= ins_ch_q + 2'h1;
				end
			end else if ((vid_in.audio && (strip_q || mode_q == MODE_OVERWRITE))
					|| (vid_in.edh && strip_q)) begin
				vid_q.data  <= BLANK_WORD;
				vid_q.audio <= 1'b0;
				vid_q.edh   <= 1'b0;
			end
		end
	end

	assign vid_out = vid_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	pres_code_a: assert property (@(posedge hclk) disable iff (!hresetn)
		pres == PRES_NONE || pres == PRES_525 || pres == PRES_625)
		else $error("Input presence code illegal.");

	overwrite_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(vid_in.audio && !vid_in.slot && mode_q == MODE_OVERWRITE) |=> !vid_out.audio)
		else $error("Incoming audio passed in overwrite mode.");

	append_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(vid_in.audio && !vid_in.slot && mode_q == MODE_APPEND && !strip_q)
		|=> vid_out.audio && vid_out.data == $past(vid_in.data))
		else $error("Incoming audio altered in append mode.");

	group_mark_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(vid_in.valid && vid_in.slot) |=> vid_out.slot && vid_out.group == $past(grp_sel_q))
		else $error("Inserted word lacks the selected group.");

	strip_edh_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(vid_in.edh && !vid_in.slot && strip_q) |=> !vid_out.edh && vid_out.data == BLANK_WORD)
		else $error("EDH word survived stripping.");

	gain_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
		gain_q[0] >= GAIN_MIN && gain_q[0] <= GAIN_MAX && gain_q[3] <= GAIN_MAX)
		else $error("Gain outside its range.");

	tie_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_pend_q && tie_q[0] && addr_q == REG_GAIN0) |=> gain_q[1] == gain_q[0])
		else $error("Tied partner gain did not follow.");

	gain_default_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_pend_q && addr_q == REG_CHAN && hwdata[CHAN_DEF_LSB + 2]) |=> gain_q[2] == GAIN_UNITY)
		else $error("Default command did not restore unity gain.");

	tick_period_a: assert property (@(posedge hclk) disable iff (!hresetn)
		tick |=> !tick [*2])
		else $error("Sample tick repeated too soon.");

endmodule // audio_embed_ctrl

// file: src/chan_gain.sv
// Gain and polarity stage for one mixer input channel.
`timescale 1ns/1ps
module chan_gain (
	// Sample in.
	input  wire logic signed [23:0] sample,
	// Controls.
	input  wire logic signed [7:0]  gain_db,
	input  wire logic               invert,
	// Result, wide enough for twelve decibels of lift.
	output logic signed [26:0]      scaled
);
	import embed_ctrl_pkg::*;

	logic [7:0]         idx;    // Gain lifted to a positive index.
	logic [3:0]         octave; // Whole six-decibel steps.
	logic [2:0]         step;   // Remaining decibels.
	logic [15:0]        frac;   // Fractional multiplier.
	logic signed [40:0] prod;   // Full product before the shift.
	logic signed [40:0] shifted;
	logic [5:0]         shamt;

	// Exponent and mantissa of the gain; six decibels double the level.
	always_comb begin
		idx    = gain_db + GAIN_BIAS;
		octave = 4'(idx / 8'd6);
		step   = 3'(idx % 8'd6);
		unique case (step)
			3'd0: frac = FRAC0;
			3'd1: frac = FRAC1;
			3'd2: frac = FRAC2;
			3'd3: frac = FRAC3;
			3'd4: frac = FRAC4;
			default: frac = FRAC5;
		endcase
		shamt   = SHIFT_BASE - 6'(octave);
		prod    = 41'(sample) * $signed({25'd0, frac});
		shifted = prod >>> shamt;
	end

	// Negation after scaling cannot overflow, since the result has spare headroom.
	assign scaled = invert ? -shifted[26:0] : shifted[26:0];

endmodule // chan_gain

// file: src/embed_ctrl_pkg.sv
// Shared constants, types and register map of the audio mixer and embedder control block.
package embed_ctrl_pkg;

	// Clock and audio timing.
	localparam int unsigned CLK_HZ            = 250_000_000; // Bus and video clock rate.
	localparam int unsigned AUDIO_HZ          = 48_000;      // Internal mixing rate.
	localparam int unsigned TICK_CYCLES       = CLK_HZ / AUDIO_HZ; // Longest period, rounded down.
	localparam int unsigned GROUP_HOLD_MS     = 40;          // Silence time before a group is absent.
	localparam int unsigned GROUP_HOLD_CYCLES = GROUP_HOLD_MS * (CLK_HZ / 1000);

	// Register byte offsets.
	localparam logic [7:0] REG_CTRL   = 8'h00; // Mode, group, reference, headroom, strip, width.
	localparam logic [7:0] REG_STATUS = 8'h04; // Input presence and group status.
	localparam logic [7:0] REG_CHAN   = 8'h08; // Tie, invert, and gain default command.
	localparam logic [7:0] REG_ROUTE  = 8'h0c; // Four routing nibbles, one per input.
	localparam logic [7:0] REG_GAIN0  = 8'h10; // Gain of input 0; inputs follow one word apart.
	localparam logic [7:0] REG_METER  = 8'h20; // Peak flags and level bands of the outputs.
	localparam logic [7:0] REG_STEP   = 8'h04; // Distance between gain words.

	// Field positions.
	localparam int unsigned CTRL_MODE_BIT  = 0;
	localparam int unsigned CTRL_GRP_LSB   = 1;
	localparam int unsigned CTRL_REF_BIT   = 3;
	localparam int unsigned CTRL_PEAK_LSB  = 4;
	localparam int unsigned CTRL_STRIP_BIT = 7;
	localparam int unsigned CTRL_W20_LSB   = 8;
	localparam int unsigned CHAN_TIE_LSB   = 0;
	localparam int unsigned CHAN_INV_LSB   = 4;
	localparam int unsigned CHAN_DEF_LSB   = 8;
	localparam int unsigned STAT_GRP_LSB   = 2;
	localparam int unsigned STAT_GVAL_BIT  = 4;
	localparam int unsigned METER_BAND_LSB = 4;

	// Gain range in whole decibels.
	localparam logic signed [7:0] GAIN_MIN   = -8'sd70;
	localparam logic signed [7:0] GAIN_MAX   = 8'sd12;
	localparam logic signed [7:0] GAIN_UNITY = 8'sd0;

	// Sample formats.
	localparam logic [23:0] W20_MASK   = 24'hfffff0; // Drops the unused bits of a 20-bit word.
	localparam logic [23:0] FULL_SCALE = 24'h7fffff;
	localparam logic [9:0]  BLANK_WORD = 10'h200;    // Neutral word left where a packet is removed.
	localparam logic [1:0]  LAST_BYTE  = 2'h2;       // Each sample is carried as three bytes.

	// Peak thresholds as magnitudes: clipping, then 2 to 10 dB below full scale.
	localparam logic [23:0] PEAK_CLIP = 24'h7ffffe;
	localparam logic [23:0] PEAK_2DB  = 24'h65ab9a;
	localparam logic [23:0] PEAK_4DB  = 24'h50c312;
	localparam logic [23:0] PEAK_6DB  = 24'h4026fb;
	localparam logic [23:0] PEAK_8DB  = 24'h32f545;
	localparam logic [23:0] PEAK_10DB = 24'h287a1d;

	// Zero-VU and minus-twenty-VU magnitudes for each reference level.
	localparam logic [23:0] VU0_REF20  = 24'h0ccccd; // -20 dBFS.
	localparam logic [23:0] VU20_REF20 = 24'h0147ae; // -40 dBFS.
	localparam logic [23:0] VU0_REF18  = 24'h101d2d; // -18 dBFS.
	localparam logic [23:0] VU20_REF18 = 24'h019c84; // -38 dBFS.

	// Fractional steps of 2^(k/6) in Q1.14 for the gain table.
	localparam logic [15:0] FRAC0 = 16'h4000;
	localparam logic [15:0] FRAC1 = 16'h47d6;
	localparam logic [15:0] FRAC2 = 16'h50a3;
	localparam logic [15:0] FRAC3 = 16'h5a82;
	localparam logic [15:0] FRAC4 = 16'h6598;
	localparam logic [15:0] FRAC5 = 16'h7209;
	localparam logic [7:0]  GAIN_BIAS  = 8'd72; // Lifts the gain to a positive index.
	localparam logic [5:0]  SHIFT_BASE = 6'd26; // Shift at the most negative octave.

	typedef enum logic [1:0] {PRES_NONE = 2'b00, PRES_525 = 2'b01, PRES_625 = 2'b10} pres_t;
	typedef enum logic {MODE_OVERWRITE = 1'b0, MODE_APPEND = 1'b1} mux_mode_t;
	typedef enum logic [1:0] {BAND_LOW = 2'b00, BAND_MID = 2'b01, BAND_HIGH = 2'b10} band_t;

	// One video word with its packet markers.
	typedef struct packed {
		logic       valid; // Word present this cycle.
		logic [9:0] data;  // Video or ancillary word.
		logic       audio; // Word belongs to an embedded audio packet.
		logic       edh;   // Word belongs to an error-detection packet.
		logic [1:0] group; // Audio group of the packet, zero based.
		logic       slot;  // In: free slot for insertion. Out: word inserted here.
	} vid_word_t;

	// One stereo input after rate conversion.
	typedef struct packed {
		logic        valid; // New sample pair this cycle.
		logic [23:0] left;
		logic [23:0] right;
	} aes_pair_t;

endpackage

// file: testbench/test_sdi_audio_embed_mixer_control.sv
// Self-checking bench of the audio embedder control block.
`timescale 1ns/1ps
module test_sdi_audio_embed_mixer_control;
	import embed_ctrl_pkg::*;

	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic        lock = 1'b0, p625 = 1'b0, hreadyout, hresp;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic [1:0]  htrans = '0, kind = '0, grp = '0;
	logic [23:0] lvl = '0;
	vid_word_t   vid_in, vid_out;
	aes_pair_t   aes_a, aes_b;
	int          mismatches = 0, n_checks = 0;

	always #2 hclk = ~hclk;

	// Short audio tick and group hold keep the run brief.
	audio_embed_ctrl #(.TICK(8), .GROUP_HOLD(50)) uut (.hclk, .hresetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
		.hrdata, .vid_lock_pin(lock), .vid_625_pin(p625), .vid_in, .vid_out, .aes_a, .aes_b);
	vid_src_model src (.hclk, .hresetn, .kind, .grp, .lvl, .vid(vid_in), .aes_a, .aes_b);

	////////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	// Ready is sampled just before the edge that takes it, so no race.
	task automatic wt;
		int n;
		n = 0;
		@(negedge hclk);
		while (hreadyout !== 1'b1 && n < 64) begin
			@(negedge hclk);
			n++;
		end
		// A slave that never answers is a failure, not a silent pass.
		if (n >= 64) begin
			mismatches++;
		end
		rd = hrdata;
		@(posedge hclk);
	endtask

	task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		wt();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wt();
	endtask

	task automatic rr(input string nm, input logic [7:0] a, input logic [31:0] e);
		xf(1'b0, a, 32'h0);
		chk(nm, e, rd);
		chk("resp", 32'h0, 32'(hresp));
	endtask

	// One word in, its image one cycle later under a field mask.
	task automatic vd(input string nm, input logic [1:0] k, input logic [15:0] m, e);
		kind <= k;
		@(posedge hclk);
		kind <= 2'd0;
		@(negedge hclk);
		chk(nm, {16'h0, e}, {16'h0, 16'(vid_out) & m});
		@(posedge hclk);
	endtask

	task automatic mx(input string nm, input logic [23:0] l, input logic [31:0] r, e);
		lvl <= l;
		xf(1'b1, REG_ROUTE, r);
		repeat (40) @(posedge hclk);
		rr(nm, REG_METER, e);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rr("ctrl", REG_CTRL, 32'h0);
		rr("route", REG_ROUTE, 32'h8421);
		for (int i = 0; i < 4; i++)
			rr("gain", REG_GAIN0 + 8'(i) * REG_STEP, 32'h0);
		rr("meter", REG_METER, 32'h0);
		xf(1'b1, 8'h30, 32'hffff);
		rr("unmapped", 8'h30, 32'h0);
		for (int p = 0; p < 3; p++) begin
			lock <= (p != 0);
			p625 <= (p == 2);
			repeat (4) @(posedge hclk);
			rr("presence", REG_STATUS, 32'(p));
		end
		xf(1'b1, REG_GAIN0, 32'd100);
		rr("gain max", REG_GAIN0, 32'hc);
		xf(1'b1, REG_GAIN0, 32'hffffff9c);
		rr("gain min", REG_GAIN0, 32'hffffffba);
		xf(1'b1, REG_CHAN, 32'h1);
		xf(1'b1, REG_GAIN0, 32'h5);
		rr("tied gain", REG_GAIN0 + REG_STEP, 32'h5);
		xf(1'b1, REG_GAIN0 + REG_STEP + REG_STEP, 32'h3);
		xf(1'b1, REG_CHAN, 32'h501);
		rr("default", REG_GAIN0, 32'h0);
		rr("default 2", REG_GAIN0 + REG_STEP + REG_STEP, 32'h0);
		rr("tied default", REG_GAIN0 + REG_STEP, 32'h0);
		rr("chan", REG_CHAN, 32'h1);
		vd("overwrite", 2'd1, 16'h7ff0, 16'h4000);
		xf(1'b1, REG_CTRL, 32'h1);
		vd("append", 2'd1, 16'hffff, 16'hf4b0);
		vd("edh pass", 2'd2, 16'hffff, 16'hf4a8);
		xf(1'b1, REG_CTRL, 32'h81);
		vd("edh strip", 2'd2, 16'h7fe0, 16'h4000);
		vd("audio strip", 2'd1, 16'h7ff0, 16'h4000);
		xf(1'b1, REG_CTRL, 32'h5);
		vd("slot", 2'd3, 16'hffff, 16'h8015);
		grp <= 2'd2;
		vd("group pass", 2'd1, 16'h0016, 16'h0014);
		rr("group valid", REG_STATUS, 32'h1a);
		repeat (60) @(posedge hclk);
		rr("group idle", REG_STATUS, 32'h0a);
		xf(1'b1, REG_CTRL, 32'h0);
		xf(1'b1, REG_CHAN, 32'h0);
		mx("all outputs", 24'h7fffff, 32'hf, 32'haaf);
		mx("no output", 24'h7fffff, 32'h0, 32'h0);
		mx("saturate", 24'h7fffff, 32'h11, 32'h21);
		xf(1'b1, REG_CTRL, 32'h100);
		mx("narrow", 24'h7fffff, 32'h1, 32'h20);
		xf(1'b1, REG_CTRL, 32'h50);
		mx("ref low", 24'h0f0000, 32'hf, 32'haa0);
		mx("peak 10 dB", 24'h300000, 32'h1, 32'h21);
		xf(1'b1, REG_CTRL, 32'h10);
		mx("peak 2 dB", 24'h600000, 32'h1, 32'h20);
		xf(1'b1, REG_CTRL, 32'h20);
		mx("peak 4 dB", 24'h600000, 32'h1, 32'h21);
		xf(1'b1, REG_CTRL, 32'h58);
		mx("ref high", 24'h0f0000, 32'hf, 32'h550);
		mx("sum", 24'h0f0000, 32'h11, 32'h20);
		xf(1'b1, REG_CHAN, 32'h20);
		mx("invert", 24'h0f0000, 32'h11, 32'h0);
		xf(1'b1, REG_GAIN0, 32'hc);
		mx("gain lift", 24'h0f0000, 32'h1, 32'h21);
		stop_test();
	end

	// A hang counts against the run and ends it the usual way.
	initial begin
		repeat (20000) @(posedge hclk);
		mismatches++;
		stop_test();
	end
endmodule // test_sdi_audio_embed_mixer_control

// file: testbench/vid_src_model.sv
// Upstream video word source and locked stereo sample source.
`timescale 1ns/1ps
module vid_src_model (
	// Clock and reset.
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// Word kind, packet group and sample level.
	input  wire logic [1:0]        kind,
	input  wire logic [1:0]        grp,
	input  wire logic [23:0]       lvl,
	// Stream and samples.
	output embed_ctrl_pkg::vid_word_t vid,
	output embed_ctrl_pkg::aes_pair_t aes_a,
	output embed_ctrl_pkg::aes_pair_t aes_b
);
	import embed_ctrl_pkg::*;

	logic [2:0] div_q; // Sample pacing, derived from the video clock.

	// Kind 1 is audio, 2 error detection, 3 a free slot, else plain video.
	assign vid = '{1'b1, 10'h3a5, kind == 2'd1, kind == 2'd2, grp, kind == 2'd3};
	assign aes_a = '{div_q == 3'd0, lvl, lvl};
	assign aes_b = '{div_q == 3'd0, 24'h000000, 24'h000000};

	////////////////////////////////////////////////////////////////
	// Samples come from a divider of hclk, so the sources stay synchronous.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_q <= 3'd0;
		end else begin
			div_q <= div_q + 3'd1;
		end
	end
endmodule // vid_src_model
